//--- verilog/nac_pkg.sv
// constants and types for the association settings command block
// ----------------------------------------------------------------
// How it works
// (RULE1) lookup hit loads destination high/low, replies OK, leaves command mode
// (RULE2) no answer within 200 ms or blank argument aborts lookup with ERROR
// (RULE3) one-bit role, 0 end device, 1 coordinator, resets to 0
// (RULE4) channel mask bit n enables channel 0x0B plus n
// (RULE5) channel mask governs every active and energy scan of every origin
// (RULE6) high-power part forbids mask bits 0, 14, 15; mask resets to 0x1FFE
// (RULE7) scan exponent 0 to 0x0F, resets to 4
// (RULE8) scan time is channels times two to exponent times 15.36 ms
// (RULE9) high-power part scans at most 13 channels, mask 0x3FFE
// (RULE10) end device: exponent sets active scan length during joining
// (RULE11) host keeps exponent at or above highest coordinator beacon exponent
// (RULE12) coordinator: exponent sets active or energy scan per reassign option
// (RULE13) option bit 0 clear: own network only; set: any network
// (RULE14) option bit 1 clear: own channel only; set: any channel
// (RULE15) option bit 2 set keeps joining until success; clear joins only on a beacon network
// (RULE16) beacon network end device always joins regardless of bit 2
// (RULE17) option bit 3 set makes pin wake-up poll the coordinator
// (RULE18) option bits 4 to 7 reserved, valid 0 to 0x0F, resets to 0
// (RULE19) out-of-range write replies ERROR and keeps stored value
// ----------------------------------------------------------------
package nac_pkg;
    localparam int CLK_HZ            = 50_000_000;
    localparam int LOOKUP_TIMEOUT_MS = 200;
    localparam int LOOKUP_TIMEOUT_CYC = LOOKUP_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int SCAN_UNIT_US      = 15360;
    localparam int SCAN_UNIT_CYC     = SCAN_UNIT_US * (CLK_HZ / 1_000_000);

    localparam logic        ROLE_RST    = 1'b0;
    localparam logic        ROLE_MAX    = 1'b1;
    localparam logic [15:0] MASK_RST    = 16'h1FFE;
    localparam logic [15:0] HP_FORBID   = 16'hC001;
    localparam logic [15:0] HP_SCAN_MAX = 16'h3FFE;
    localparam logic [3:0]  EXP_RST     = 4'h4;
    localparam logic [15:0] EXP_MAX     = 16'h000F;
    localparam logic [7:0]  OPT_RST     = 8'h00;
    localparam logic [15:0] OPT_MAX     = 16'h000F;
    localparam logic [7:0]  FIRST_CHAN  = 8'h0B;
    localparam int          OPT_ANY_NET  = 0;
    localparam int          OPT_ANY_FREQ = 1;
    localparam int          OPT_KEEP     = 2;
    localparam int          OPT_POLL     = 3;
    localparam int          SCAN_TIME_W  = 20;

    typedef enum logic [3:0] {
        OP_RD_ROLE, OP_WR_ROLE, OP_RD_MASK, OP_WR_MASK,
        OP_RD_EXP, OP_WR_EXP, OP_RD_OPT, OP_WR_OPT, OP_LOOKUP
    } nac_op_t;

    typedef enum logic [1:0] {
        SK_CMD_ACTIVE, SK_CMD_ENERGY, SK_JOIN, SK_COORD_START
    } nac_scan_kind_t;

    typedef struct packed {
        nac_op_t     op;
        logic [15:0] value;
        logic        blank;
    } nac_cmd_t;

    typedef struct packed {
        logic        ok;
        logic        err;
        logic [15:0] data;
    } nac_reply_t;

    typedef enum {LK_IDLE, LK_WAIT} nac_lk_state_t;
    typedef enum {SC_IDLE, SC_DWELL} nac_sc_state_t;
endpackage : nac_pkg

//--- verilog/nac_top.sv
// association settings, name lookup and scan sequencing
`timescale 1ns/100ps
`default_nettype none
module nac_top #(
    parameter bit HIGH_POWER  = 1'b1,
    parameter int TIMEOUT_CYC = nac_pkg::LOOKUP_TIMEOUT_CYC,
    parameter int UNIT_CYC    = nac_pkg::SCAN_UNIT_CYC
) (
    input  wire logic                     SYS_CLK_IN,
    input  wire logic                     RST_N_IN,
    input  wire logic                     CMD_VALID_IN,
    input  wire nac_pkg::nac_cmd_t        CMD_IN,
    output logic                          CMD_READY_OUT,
    output nac_pkg::nac_reply_t           REPLY_OUT,
    output logic                          EXIT_CMD_MODE_OUT,
    output logic                          LOOKUP_REQ_OUT,
    input  wire logic                     LOOKUP_HIT_IN,
    input  wire logic [63:0]              LOOKUP_ADDR_IN,
    output logic [31:0]                   DEST_ADDR_HIGH_OUT,
    output logic [31:0]                   DEST_ADDR_LOW_OUT,
    output logic                          ROLE_OUT,
    output logic [15:0]                   CHANNEL_MASK_OUT,
    output logic [3:0]                    SCAN_EXP_OUT,
    output logic [7:0]                    JOIN_OPTIONS_OUT,
    input  wire logic                     BEACON_NET_IN,
    output logic                          ANY_NETWORK_ALLOWED_OUT,
    output logic                          ANY_FREQUENCY_ALLOWED_OUT,
    output logic                          JOIN_ENABLE_OUT,
    input  wire logic                     WAKE_PIN_IN,
    output logic                          POLL_REQ_OUT,
    input  wire logic                     SCAN_REQ_IN,
    input  wire nac_pkg::nac_scan_kind_t  SCAN_KIND_IN,
    input  wire logic                     COORD_NET_REASSIGN_IN,
    input  wire logic                     COORD_CHAN_REASSIGN_IN,
    output logic                          SCAN_BUSY_OUT,
    output logic                          SCAN_ENERGY_OUT,
    output logic [7:0]                    SCAN_CHAN_OUT,
    output logic                          SCAN_DONE_OUT,
    output logic [nac_pkg::SCAN_TIME_W-1:0] SCAN_TIME_OUT
);
    localparam int LKW = $clog2(TIMEOUT_CYC + 1);
    localparam int UW  = $clog2(UNIT_CYC + 1);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [4:0] nac_find(input logic [15:0] m, input logic [4:0] from);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (5'(i) >= from && m[i]) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction : nac_find

    function automatic logic [4:0] nac_count(input logic [15:0] m);
        logic [4:0] c;
        c = 5'h00;
        for (int i = 0; i < 16; i++) begin
            c = c + 5'(m[i]);
        end
        return c;
    endfunction : nac_count

    // ----------------------------------------------------------------
    // settings and command decode
    // ----------------------------------------------------------------
    logic                   role_q;
    logic [15:0]            mask_q;
    logic [3:0]             exp_q;
    logic [7:0]             opt_q;
    nac_pkg::nac_lk_state_t lk_state_q;
    logic [LKW-1:0]         lk_cnt_q;
    logic                   is_wr;
    logic                   wr_ok;
    logic                   take;
    logic [15:0]            rd_data;

    assign CMD_READY_OUT = (lk_state_q == nac_pkg::LK_IDLE);
    assign take          = CMD_VALID_IN && CMD_READY_OUT;

    always_comb begin
        is_wr   = 1'b0;
        wr_ok   = 1'b0;
        rd_data = 16'h0000;
        unique case (CMD_IN.op)
            nac_pkg::OP_RD_ROLE: rd_data = 16'(role_q);
            nac_pkg::OP_RD_MASK: rd_data = mask_q;
            nac_pkg::OP_RD_EXP:  rd_data = 16'(exp_q);
            nac_pkg::OP_RD_OPT:  rd_data = 16'(opt_q);
            nac_pkg::OP_WR_ROLE: begin
                is_wr = 1'b1;
                wr_ok = CMD_IN.value <= 16'(nac_pkg::ROLE_MAX); // [RULE3] [RULE19]
            end
            nac_pkg::OP_WR_MASK: begin
                is_wr = 1'b1;
                wr_ok = !(HIGH_POWER && |(CMD_IN.value & nac_pkg::HP_FORBID)); // [RULE6]
            end
            nac_pkg::OP_WR_EXP: begin
                is_wr = 1'b1;
                wr_ok = CMD_IN.value <= nac_pkg::EXP_MAX; // [RULE7] [RULE19]
            end
            nac_pkg::OP_WR_OPT: begin
                is_wr = 1'b1;
                wr_ok = CMD_IN.value <= nac_pkg::OPT_MAX; // [RULE18] [RULE19]
            end
            nac_pkg::OP_LOOKUP: rd_data = 16'h0000;
            default:            rd_data = 16'h0000;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            role_q <= nac_pkg::ROLE_RST; // [RULE3]
            mask_q <= nac_pkg::MASK_RST; // [RULE6]
            exp_q  <= nac_pkg::EXP_RST;  // [RULE7]
            opt_q  <= nac_pkg::OPT_RST;  // [RULE18]
        end else if (take && is_wr && wr_ok) begin
            unique case (CMD_IN.op)
                nac_pkg::OP_WR_ROLE: role_q <= CMD_IN.value[0];
                nac_pkg::OP_WR_MASK: mask_q <= CMD_IN.value; // [RULE4]
                nac_pkg::OP_WR_EXP:  exp_q  <= CMD_IN.value[3:0];
                nac_pkg::OP_WR_OPT:  opt_q  <= CMD_IN.value[7:0];
                default:             opt_q  <= opt_q;
            endcase
        end
    end

    assign ROLE_OUT         = role_q;
    assign CHANNEL_MASK_OUT = mask_q;
    assign SCAN_EXP_OUT     = exp_q;
    assign JOIN_OPTIONS_OUT = opt_q;

    // ----------------------------------------------------------------
    // name lookup and replies
    // ----------------------------------------------------------------
    logic        lk_expire;
    logic [31:0] dest_hi_q;
    logic [31:0] dest_lo_q;
    nac_pkg::nac_reply_t reply_q;
    logic        exit_q;
    logic        lk_req_q;

    assign lk_expire = (lk_cnt_q == LKW'(TIMEOUT_CYC - 1));

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            lk_state_q <= nac_pkg::LK_IDLE;
            lk_cnt_q   <= '0;
            lk_req_q   <= 1'b0;
        end else begin
            lk_req_q <= 1'b0;
            unique case (lk_state_q)
                nac_pkg::LK_IDLE: begin
                    lk_cnt_q <= '0;
                    if (take && CMD_IN.op == nac_pkg::OP_LOOKUP && !CMD_IN.blank) begin
                        lk_state_q <= nac_pkg::LK_WAIT;
                        lk_req_q   <= 1'b1;
                    end
                end
                nac_pkg::LK_WAIT: begin
                    lk_cnt_q <= lk_cnt_q + LKW'(1);
                    if (LOOKUP_HIT_IN || lk_expire) begin
                        lk_state_q <= nac_pkg::LK_IDLE; // [RULE2]
                    end
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            dest_hi_q <= 32'h0000_0000;
            dest_lo_q <= 32'h0000_0000;
        end else if (lk_state_q == nac_pkg::LK_WAIT && LOOKUP_HIT_IN) begin
            dest_hi_q <= LOOKUP_ADDR_IN[63:32]; // [RULE1]
            dest_lo_q <= LOOKUP_ADDR_IN[31:0];  // [RULE1]
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            reply_q <= '0;
            exit_q  <= 1'b0;
        end else begin
            reply_q.ok  <= 1'b0;
            reply_q.err <= 1'b0;
            exit_q      <= 1'b0;
            if (lk_state_q == nac_pkg::LK_WAIT) begin
                if (LOOKUP_HIT_IN) begin
                    reply_q.ok <= 1'b1; // [RULE1]
                    exit_q     <= 1'b1; // [RULE1]
                end else if (lk_expire) begin
                    reply_q.err <= 1'b1; // [RULE2]
                end
            end else if (CMD_VALID_IN) begin
                if (CMD_IN.op == nac_pkg::OP_LOOKUP) begin
                    reply_q.err <= CMD_IN.blank; // [RULE2]
                end else begin
                    reply_q.ok   <= !is_wr || wr_ok;
                    reply_q.err  <= is_wr && !wr_ok; // [RULE19]
                    reply_q.data <= rd_data;
                end
            end
        end
    end

    assign REPLY_OUT          = reply_q;
    assign EXIT_CMD_MODE_OUT  = exit_q;
    assign LOOKUP_REQ_OUT     = lk_req_q;
    assign DEST_ADDR_HIGH_OUT = dest_hi_q;
    assign DEST_ADDR_LOW_OUT  = dest_lo_q;

    // ----------------------------------------------------------------
    // joining options and pin wake poll
    // ----------------------------------------------------------------
    logic wake_s1_q;
    logic wake_s2_q;
    logic wake_s3_q;
    logic poll_q;

    assign ANY_NETWORK_ALLOWED_OUT   = opt_q[nac_pkg::OPT_ANY_NET];  // [RULE13]
    assign ANY_FREQUENCY_ALLOWED_OUT = opt_q[nac_pkg::OPT_ANY_FREQ]; // [RULE14]
    assign JOIN_ENABLE_OUT = !role_q &&
        (BEACON_NET_IN || opt_q[nac_pkg::OPT_KEEP]); // [RULE15] [RULE16]

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
            wake_s3_q <= 1'b0;
            poll_q    <= 1'b0;
        end else begin
            wake_s1_q <= WAKE_PIN_IN;
            wake_s2_q <= wake_s1_q;
            wake_s3_q <= wake_s2_q;
            poll_q    <= wake_s2_q && !wake_s3_q && opt_q[nac_pkg::OPT_POLL]; // [RULE17]
        end
    end

    assign POLL_REQ_OUT = poll_q;

    // ----------------------------------------------------------------
    // scan sequencing
    // ----------------------------------------------------------------
    nac_pkg::nac_sc_state_t sc_state_q;
    logic [15:0]    mask_eff;
    logic [15:0]    scan_mask_q;
    logic [3:0]     chan_idx_q;
    logic           energy_q;
    logic           energy_next_q;
    logic           done_q;
    logic [UW-1:0]  unit_cnt_q;
    logic [15:0]    rep_cnt_q;
    logic [4:0]     first_hit;
    logic [4:0]     again_hit;
    logic [4:0]     next_hit;
    logic           dwell_end;
    logic           want_act;
    logic           want_en;
    logic [nac_pkg::SCAN_TIME_W-1:0] time_q;

    assign mask_eff  = HIGH_POWER ? (mask_q & nac_pkg::HP_SCAN_MAX) : mask_q; // [RULE9]
    assign first_hit = nac_find(mask_eff, 5'h00); // [RULE5]
    assign again_hit = nac_find(scan_mask_q, 5'h00);
    assign next_hit  = nac_find(scan_mask_q, 5'(chan_idx_q) + 5'h01);
    assign dwell_end = (unit_cnt_q == UW'(UNIT_CYC - 1)) &&
                       (rep_cnt_q == ((16'h0001 << exp_q) - 16'h0001)); // [RULE10] [RULE12]

    always_comb begin
        want_act = 1'b0;
        want_en  = 1'b0;
        unique case (SCAN_KIND_IN)
            nac_pkg::SK_CMD_ACTIVE:  want_act = 1'b1;
            nac_pkg::SK_CMD_ENERGY:  want_en  = 1'b1;
            nac_pkg::SK_JOIN:        want_act = 1'b1; // [RULE10]
            nac_pkg::SK_COORD_START: begin
                want_act = COORD_NET_REASSIGN_IN;  // [RULE12]
                want_en  = COORD_CHAN_REASSIGN_IN; // [RULE12]
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sc_state_q    <= nac_pkg::SC_IDLE;
            scan_mask_q   <= 16'h0000;
            chan_idx_q    <= 4'h0;
            energy_q      <= 1'b0;
            energy_next_q <= 1'b0;
            done_q        <= 1'b0;
            unit_cnt_q    <= '0;
            rep_cnt_q     <= 16'h0000;
        end else begin
            done_q <= 1'b0;
            unique case (sc_state_q)
                nac_pkg::SC_IDLE: begin
                    unit_cnt_q <= '0;
                    rep_cnt_q  <= 16'h0000;
                    if (SCAN_REQ_IN) begin
                        scan_mask_q   <= mask_eff;
                        energy_q      <= want_en && !want_act;
                        energy_next_q <= want_en && want_act;
                        chan_idx_q    <= first_hit[3:0];
                        if (first_hit[4] && (want_act || want_en)) begin
                            sc_state_q <= nac_pkg::SC_DWELL;
                        end else begin
                            done_q <= 1'b1;
                        end
                    end
                end
                nac_pkg::SC_DWELL: begin
                    if (unit_cnt_q == UW'(UNIT_CYC - 1)) begin
                        unit_cnt_q <= '0;
                        rep_cnt_q  <= rep_cnt_q + 16'h0001;
                    end else begin
                        unit_cnt_q <= unit_cnt_q + UW'(1);
                    end
                    if (dwell_end) begin
                        rep_cnt_q <= 16'h0000;
                        if (next_hit[4]) begin
                            chan_idx_q <= next_hit[3:0];
                        end else if (energy_next_q) begin
                            energy_next_q <= 1'b0;
                            energy_q      <= 1'b1;
                            chan_idx_q    <= again_hit[3:0];
                        end else begin
                            sc_state_q <= nac_pkg::SC_IDLE;
                            done_q     <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            time_q <= '0;
        end else begin
            time_q <= nac_pkg::SCAN_TIME_W'(nac_count(mask_eff)) << exp_q; // [RULE8]
        end
    end

    assign SCAN_BUSY_OUT   = (sc_state_q == nac_pkg::SC_DWELL);
    assign SCAN_ENERGY_OUT = energy_q;
    assign SCAN_CHAN_OUT   = nac_pkg::FIRST_CHAN + 8'(chan_idx_q); // [RULE4]
    assign SCAN_DONE_OUT   = done_q;
    assign SCAN_TIME_OUT   = time_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_hit;
        lk_state_q == nac_pkg::LK_WAIT && LOOKUP_HIT_IN;
    endsequence

    property p_lookup_ok;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        s_hit |=> REPLY_OUT.ok && EXIT_CMD_MODE_OUT &&
            {DEST_ADDR_HIGH_OUT, DEST_ADDR_LOW_OUT} == $past(LOOKUP_ADDR_IN);
    endproperty
    a_lookup_ok: assert property (p_lookup_ok) else $error("lookup hit not applied"); // [RULE1]

    property p_timeout;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        lk_state_q == nac_pkg::LK_WAIT && lk_expire && !LOOKUP_HIT_IN
        |=> REPLY_OUT.err && !EXIT_CMD_MODE_OUT && CMD_READY_OUT;
    endproperty
    a_timeout: assert property (p_timeout) else $error("lookup timeout missed"); // [RULE2]

    property p_blank;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        take && CMD_IN.op == nac_pkg::OP_LOOKUP && CMD_IN.blank
        |=> REPLY_OUT.err && !LOOKUP_REQ_OUT;
    endproperty
    a_blank: assert property (p_blank) else $error("blank lookup not refused"); // [RULE2]

    property p_reject;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        take && is_wr && !wr_ok
        |=> REPLY_OUT.err && $stable(opt_q) && $stable(exp_q) && $stable(mask_q) &&
            $stable(role_q);
    endproperty
    a_reject: assert property (p_reject) else $error("bad write changed a setting"); // [RULE19]

    property p_exp_wr;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        take && CMD_IN.op == nac_pkg::OP_WR_EXP && wr_ok
        |=> exp_q == $past(CMD_IN.value[3:0]) && REPLY_OUT.ok;
    endproperty
    a_exp_wr: assert property (p_exp_wr) else $error("exponent write lost"); // [RULE7]

    property p_hp_mask;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        HIGH_POWER |-> !(|(mask_q & nac_pkg::HP_FORBID));
    endproperty
    a_hp_mask: assert property (p_hp_mask) else $error("forbidden channel stored"); // [RULE6]

    property p_scan_chan;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        SCAN_BUSY_OUT |-> scan_mask_q[chan_idx_q] &&
            !(HIGH_POWER && |(scan_mask_q & ~nac_pkg::HP_SCAN_MAX));
    endproperty
    a_scan_chan: assert property (p_scan_chan) else $error("disabled channel scanned"); // [RULE5]

    property p_join;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        !role_q && BEACON_NET_IN |-> JOIN_ENABLE_OUT;
    endproperty
    a_join: assert property (p_join) else $error("beacon end device not joining"); // [RULE16]

    property p_poll;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        wake_s2_q && !wake_s3_q |=> POLL_REQ_OUT == $past(opt_q[nac_pkg::OPT_POLL]);
    endproperty
    a_poll: assert property (p_poll) else $error("wake poll wrong"); // [RULE17]

    property p_time;
        @(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        $stable(mask_q) && $stable(exp_q) |=>
            SCAN_TIME_OUT == (nac_pkg::SCAN_TIME_W'(nac_count($past(mask_eff))) << $past(exp_q));
    endproperty
    a_time: assert property (p_time) else $error("scan time wrong"); // [RULE8]
endmodule : nac_top
`default_nettype wire

//--- testbench/nac_lookup_peer.sv
// far-side name resolver model answering lookup requests
`timescale 1ns/100ps
`default_nettype none
module nac_lookup_peer #(
    parameter int          DELAY = 3,
    parameter logic [63:0] ADDR  = 64'h1234_5678_9ABC_DEF0
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        req_in,
    input  wire logic        answer_in,
    output logic             hit_out,
    output logic [63:0]      addr_out
);
    int cnt;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt <= 0;
        end else if (req_in && answer_in) begin
            cnt <= DELAY;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    // address only meaningful with hit; otherwise inverted
    assign hit_out  = (cnt == 1);
    assign addr_out = hit_out ? ADDR : ~ADDR;
endmodule : nac_lookup_peer
`default_nettype wire

//--- testbench/test_nac_top.sv
// self-checking bench for the association settings block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module test_nac_top;
    logic clk = 0, rst_n = 0, cv = 0, beacon = 0, wake = 0, sreq = 0, nr = 0, cr = 0, ans = 1;
    nac_pkg::nac_cmd_t       cmd  = '0;
    nac_pkg::nac_scan_kind_t kind = nac_pkg::SK_CMD_ACTIVE;
    nac_pkg::nac_reply_t     rep;
    logic        rdy, ex, lreq, hit, role, en_o, busy, done, anyn, anyf, join_en, poll;
    logic [63:0] laddr;
    logic [31:0] dh, dl;
    logic [15:0] mask;
    logic [3:0]  sexp;
    logic [7:0]  opt, chan;
    logic [19:0] stime;
    int          n_fail = 0, n_tests = 0, cyc = 0;
    always #10 clk = ~clk;

    nac_top #(.HIGH_POWER(1'b1), .TIMEOUT_CYC(20), .UNIT_CYC(4)) i_nac_top (
        .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .CMD_VALID_IN(cv), .CMD_IN(cmd),
        .CMD_READY_OUT(rdy), .REPLY_OUT(rep), .EXIT_CMD_MODE_OUT(ex), .LOOKUP_REQ_OUT(lreq),
        .LOOKUP_HIT_IN(hit), .LOOKUP_ADDR_IN(laddr), .DEST_ADDR_HIGH_OUT(dh),
        .DEST_ADDR_LOW_OUT(dl), .ROLE_OUT(role), .CHANNEL_MASK_OUT(mask), .SCAN_EXP_OUT(sexp),
        .JOIN_OPTIONS_OUT(opt), .BEACON_NET_IN(beacon), .ANY_NETWORK_ALLOWED_OUT(anyn),
        .ANY_FREQUENCY_ALLOWED_OUT(anyf), .JOIN_ENABLE_OUT(join_en), .WAKE_PIN_IN(wake),
        .POLL_REQ_OUT(poll), .SCAN_REQ_IN(sreq), .SCAN_KIND_IN(kind),
        .COORD_NET_REASSIGN_IN(nr), .COORD_CHAN_REASSIGN_IN(cr), .SCAN_BUSY_OUT(busy),
        .SCAN_ENERGY_OUT(en_o), .SCAN_CHAN_OUT(chan), .SCAN_DONE_OUT(done),
        .SCAN_TIME_OUT(stime));

    nac_lookup_peer i_nac_lookup_peer (.clk_in(clk), .rst_n_in(rst_n), .req_in(lreq),
        .answer_in(ans), .hit_out(hit), .addr_out(laddr));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // one command, wait for its reply, check ok versus err
    task automatic do_cmd(input nac_pkg::nac_op_t o, input logic [15:0] v, input logic b,
                          input logic eok);
        int n;
        n = 0;
        @(posedge clk);
        cv  <= 1'b1;
        cmd <= '{op: o, value: v, blank: b};
        @(posedge clk);
        cv <= 1'b0;
        #1;
        while (rep.ok !== 1'b1 && rep.err !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("reply ok/err", {eok, ~eok}, {rep.ok, rep.err})
    endtask : do_cmd

    task automatic rd(input nac_pkg::nac_op_t o, input logic [15:0] ed);
        do_cmd(o, 16'h0000, 1'b0, 1'b1);
        `CHK("read data", ed, rep.data)
    endtask : rd

    // scan request; count busy cycles until done
    task automatic scan(input nac_pkg::nac_scan_kind_t k, input logic a, input logic c,
                        input int ecyc, input logic een);
        int n;
        n = 0;
        @(posedge clk);
        sreq <= 1'b1;
        kind <= k;
        nr   <= a;
        cr   <= c;
        @(posedge clk);
        sreq <= 1'b0;
        #1;
        if (ecyc > 0) begin
            `CHK("energy", een, en_o)
            `CHK("first chan", 8'h0C, chan)
        end
        while (busy === 1'b1 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("dwell cycles", ecyc, n)
        `CHK("done", 1'b1, done)
    endtask : scan

    task automatic wake_chk(input int ep);
        int p;
        p = 0;
        @(posedge clk);
        wake <= 1'b1;
        repeat (6) begin
            @(posedge clk);
            #1;
            p += int'(poll === 1'b1);
        end
        wake <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("poll pulses", ep, p)
    endtask : wake_chk

    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(nac_pkg::OP_RD_ROLE, 16'h0000);
        rd(nac_pkg::OP_RD_MASK, 16'h1FFE);
        rd(nac_pkg::OP_RD_EXP, 16'h0004);
        rd(nac_pkg::OP_RD_OPT, 16'h0000);
        do_cmd(nac_pkg::OP_WR_ROLE, 16'h0002, 1'b0, 1'b0);
        do_cmd(nac_pkg::OP_WR_ROLE, 16'h0001, 1'b0, 1'b1);
        `CHK("role out", 1'b1, role)
        rd(nac_pkg::OP_RD_ROLE, 16'h0001);
        do_cmd(nac_pkg::OP_WR_MASK, 16'h8006, 1'b0, 1'b0);
        rd(nac_pkg::OP_RD_MASK, 16'h1FFE);
        do_cmd(nac_pkg::OP_WR_MASK, 16'h0006, 1'b0, 1'b1);
        `CHK("mask out", 16'h0006, mask)
        do_cmd(nac_pkg::OP_WR_EXP, 16'h0010, 1'b0, 1'b0);
        do_cmd(nac_pkg::OP_WR_EXP, 16'h0001, 1'b0, 1'b1);
        `CHK("exp out", 4'h1, sexp)
        repeat (2) @(posedge clk);
        #1;
        `CHK("scan time", 20'h0_0004, stime)
        scan(nac_pkg::SK_COORD_START, 1'b1, 1'b1, 32, 1'b0);
        scan(nac_pkg::SK_COORD_START, 1'b0, 1'b1, 16, 1'b1);
        scan(nac_pkg::SK_COORD_START, 1'b0, 1'b0, 0, 1'b0);
        do_cmd(nac_pkg::OP_WR_ROLE, 16'h0000, 1'b0, 1'b1);
        scan(nac_pkg::SK_JOIN, 1'b0, 1'b0, 16, 1'b0);
        scan(nac_pkg::SK_CMD_ENERGY, 1'b0, 1'b0, 16, 1'b1);
        scan(nac_pkg::SK_CMD_ACTIVE, 1'b0, 1'b0, 16, 1'b0);
        do_cmd(nac_pkg::OP_WR_EXP, 16'h000F, 1'b0, 1'b1);
        do_cmd(nac_pkg::OP_WR_MASK, 16'h3FFE, 1'b0, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        `CHK("scan time max", 20'h6_8000, stime)
        do_cmd(nac_pkg::OP_WR_OPT, 16'h0010, 1'b0, 1'b0);
        do_cmd(nac_pkg::OP_WR_OPT, 16'h0001, 1'b0, 1'b1);
        `CHK("any net/freq", 2'b10, {anyn, anyf})
        do_cmd(nac_pkg::OP_WR_OPT, 16'h0002, 1'b0, 1'b1);
        `CHK("any net/freq", 2'b01, {anyn, anyf})
        `CHK("join off", 1'b0, join_en)
        do_cmd(nac_pkg::OP_WR_OPT, 16'h0004, 1'b0, 1'b1);
        `CHK("join on", 1'b1, join_en)
        do_cmd(nac_pkg::OP_WR_OPT, 16'h0000, 1'b0, 1'b1);
        @(posedge clk);
        beacon <= 1'b1;
        #1;
        `CHK("beacon join", 1'b1, join_en)
        wake_chk(0);
        do_cmd(nac_pkg::OP_WR_OPT, 16'h0008, 1'b0, 1'b1);
        `CHK("opt out", 8'h08, opt)
        wake_chk(1);
        do_cmd(nac_pkg::OP_LOOKUP, 16'h0000, 1'b1, 1'b0);
        do_cmd(nac_pkg::OP_LOOKUP, 16'h0000, 1'b0, 1'b1);
        `CHK("exit", 1'b1, ex)
        `CHK("dest", 64'h1234_5678_9ABC_DEF0, {dh, dl})
        ans <= 1'b0;
        do_cmd(nac_pkg::OP_LOOKUP, 16'h0000, 1'b0, 1'b0);
        `CHK("ready", 1'b1, rdy)
        give_verdict();
    end
endmodule : test_nac_top
`default_nettype wire
